// File: verilog/cfr_defines.vh
// Register offsets, field positions and codes of the feature control bank.
// Assumes inclusion by bare name from the bank's design file.
`ifndef CFR_DEFINES_VH
`define CFR_DEFINES_VH

// ------------------------------------------------------------
// Register offsets on the serial register port
// ------------------------------------------------------------
`define CFR_ADDR_LOS_SQUELCH   8'h11
`define CFR_ADDR_OUT_SEQ       8'h22
`define CFR_ADDR_FEATURE       8'h1F
`define CFR_ADDR_HOLDOVER      8'h34

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CFR_BIT_BOOST          0
`define CFR_BIT_SQUELCH_MODE   1
`define CFR_BIT_LOS_POL        2
`define CFR_BIT_PRBS_INIT      3
`define CFR_BIT_CLK_DIS        5
`define CFR_BIT_DATA_DIS       6
`define CFR_BIT_CDR_BYPASS     7
`define CFR_BIT_HOLDOVER       1
`define CFR_MODE_HI            2
`define CFR_MODE_LO            0

// ------------------------------------------------------------
// Codes and reset values
// ------------------------------------------------------------
`define CFR_FEAT_DDR           3'h2
`define CFR_FEAT_PRBS          3'h5
`define CFR_PRBS_OFF           3'h0
`define CFR_PRBS_GEN           3'h1
`define CFR_PRBS_DET           3'h4
`define CFR_RESET_BYTE         8'h00
`define CFR_HOLDOVER_ONLY      8'h02

`endif

// File: verilog/cfr_feature_ctrl.v
// Write-side feature control bank of the clock and data recovery receiver.
// Assumes a serial interface front end handing over decoded byte writes
// (address, data, one-cycle strobe) on core_clk; raw pins pass three flops.
// How it works
// RULE1: Squelch mode 0 mutes clock and data; 1 mutes only one.
// RULE2: Data output buffer enabled while its disable bit is zero.
// RULE3: Clock output buffer enabled while its disable bit is zero.
// RULE4: Sequence starts on written one then zero, never on a level.
// RULE5: Feature field 010 switches outputs to double data rate.
// RULE6: Feature field 101 enables sequence generator and detector path.
// RULE7: Host writes only 010 or 101 to feature field; others reserved.
// RULE8: Holdover entered when register holds only its holdover bit set.
// RULE9: Loss indicator active high when polarity bit zero, else low.
// RULE10: Mode field 000 powers down, 001 generates, 100 detects.
`timescale 1ns/1ps
`default_nettype none
`include "cfr_defines.vh"

module cfr_feature_ctrl (
  input  wire       core_clk,
  input  wire       arst_n,
  input  wire       wr_stb,
  input  wire [7:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire       squelch_req,
  input  wire       signal_loss_raw,
  output reg        signal_loss_indicator,
  output reg        retimed_data_output_en,
  output reg        recovered_clock_output_en,
  output reg        squelch_clk,
  output reg        squelch_data,
  output reg        ddr_en,
  output reg        prbs_path_en,
  output reg        prbs_gen_en,
  output reg        prbs_det_en,
  output reg        prbs_start,
  output reg        holdover_en,
  output reg        cdr_bypass,
  output reg        boost_output
);

  // ------------------------------------------------------------
  // Register bank
  // ------------------------------------------------------------
  reg [7:0] los_squelch_control_r;
  reg [7:0] output_and_sequence_control_r;
  reg [7:0] feature_enable_control_r;
  reg [7:0] holdover_select_r;
  reg       init_prev_r;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      los_squelch_control_r         <= `CFR_RESET_BYTE;
      output_and_sequence_control_r <= `CFR_RESET_BYTE;
      feature_enable_control_r      <= `CFR_RESET_BYTE;
      holdover_select_r             <= `CFR_RESET_BYTE;
    end else if (wr_stb) begin
      case (wr_addr)
        `CFR_ADDR_LOS_SQUELCH: los_squelch_control_r         <= wr_data;
        `CFR_ADDR_OUT_SEQ:     output_and_sequence_control_r <= wr_data;
        `CFR_ADDR_FEATURE:     feature_enable_control_r      <= wr_data;
        `CFR_ADDR_HOLDOVER:    holdover_select_r             <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin synchroniser for loss and squelch requests
  // ------------------------------------------------------------
  // Change accepted only when second and third stages agree
  reg [2:0] los_sync_r;
  reg [2:0] sq_sync_r;
  reg       los_clean_r;
  reg       sq_clean_r;
  reg       sq_alt_r;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      los_sync_r  <= 3'h0;
      sq_sync_r   <= 3'h0;
      los_clean_r <= 1'b0;
      sq_clean_r  <= 1'b0;
    end else begin
      los_sync_r <= {los_sync_r[1:0], signal_loss_raw};
      sq_sync_r  <= {sq_sync_r[1:0], squelch_req};
      if (los_sync_r[1] == los_sync_r[2])
        los_clean_r <= los_sync_r[2];
      if (sq_sync_r[1] == sq_sync_r[2])
        sq_clean_r <= sq_sync_r[2];
    end
  end

  // ------------------------------------------------------------
  // Decoded fields
  // ------------------------------------------------------------
  wire [2:0] feat_w;
  wire [2:0] mode_w;
  wire       init_w;
  wire       sqmd_w;
  wire       lospol_w;
  wire       datdis_w;
  wire       clkdis_w;
  wire       path_w;
  wire       ddr_w;
  wire       gen_w;
  wire       det_w;
  wire       hold_w;
  wire       sq_end_w;

  assign feat_w   = feature_enable_control_r[`CFR_MODE_HI:`CFR_MODE_LO];
  assign mode_w   =
    output_and_sequence_control_r[`CFR_MODE_HI:`CFR_MODE_LO];
  assign init_w   = output_and_sequence_control_r[`CFR_BIT_PRBS_INIT];
  assign sqmd_w   = los_squelch_control_r[`CFR_BIT_SQUELCH_MODE];
  assign lospol_w = los_squelch_control_r[`CFR_BIT_LOS_POL];
  assign datdis_w = output_and_sequence_control_r[`CFR_BIT_DATA_DIS];
  assign clkdis_w = output_and_sequence_control_r[`CFR_BIT_CLK_DIS];
  // Reserved feature codes decode to neither path
  assign path_w   = (feat_w == `CFR_FEAT_PRBS); // see RULE6
  assign ddr_w    = (feat_w == `CFR_FEAT_DDR);  // see RULE5
  assign gen_w    = path_w & (mode_w == `CFR_PRBS_GEN); // see RULE10
  assign det_w    = path_w & (mode_w == `CFR_PRBS_DET); // see RULE10
  // Exact byte: stray set bits keep holdover off
  assign hold_w   = (holdover_select_r == `CFR_HOLDOVER_ONLY); // see RULE8
  // Episode over: clean request gone while a mute still shows
  assign sq_end_w = ~sq_clean_r & (squelch_clk | squelch_data);

  // ------------------------------------------------------------
  // Loss indicator
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      signal_loss_indicator <= 1'b0;
    end else begin
      // Polarity bit flips the indicator sense
      signal_loss_indicator <= los_clean_r ^ lospol_w; // see RULE9
    end
  end

  // ------------------------------------------------------------
  // Output buffer enables
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      retimed_data_output_en    <= 1'b0;
      recovered_clock_output_en <= 1'b0;
    end else begin
      retimed_data_output_en    <= ~datdis_w; // see RULE2
      recovered_clock_output_en <= ~clkdis_w; // see RULE3
    end
  end

  // ------------------------------------------------------------
  // Squelch
  // ------------------------------------------------------------
  // Single-output mode mutes clock or data, clock after reset; the choice
  // flips at the end of every episode in either mode, never mid-episode
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sq_alt_r     <= 1'b0;
      squelch_clk  <= 1'b0;
      squelch_data <= 1'b0;
    end else begin
      if (sq_end_w) begin
        sq_alt_r <= ~sq_alt_r;
      end
      squelch_clk  <= sq_clean_r & (~sqmd_w | ~sq_alt_r); // see RULE1
      squelch_data <= sq_clean_r & (~sqmd_w | sq_alt_r);  // see RULE1
    end
  end

  // ------------------------------------------------------------
  // Feature and sequence modes
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ddr_en       <= 1'b0;
      prbs_path_en <= 1'b0;
      prbs_gen_en  <= 1'b0;
      prbs_det_en  <= 1'b0;
    end else begin
      ddr_en       <= ddr_w;  // see RULE5
      prbs_path_en <= path_w; // see RULE6
      prbs_gen_en  <= gen_w;  // see RULE10
      prbs_det_en  <= det_w;  // see RULE10
    end
  end

  // ------------------------------------------------------------
  // Sequence start pulse
  // ------------------------------------------------------------
  // Falling edge of the written bit: a held one never restarts
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_prev_r <= 1'b0;
      prbs_start  <= 1'b0;
    end else begin
      init_prev_r <= init_w;
      prbs_start  <= init_prev_r & ~init_w; // see RULE4
    end
  end

  // ------------------------------------------------------------
  // Holdover
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      holdover_en <= 1'b0;
    end else begin
      holdover_en <= hold_w; // see RULE8
    end
  end

  // ------------------------------------------------------------
  // Pass-through controls
  // ------------------------------------------------------------
  // Only carried to the analog side; no logic acts on them here
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cdr_bypass   <= 1'b0;
      boost_output <= 1'b0;
    end else begin
      cdr_bypass   <= output_and_sequence_control_r[`CFR_BIT_CDR_BYPASS];
      boost_output <= los_squelch_control_r[`CFR_BIT_BOOST];
    end
  end

endmodule
`default_nettype wire

// File: verification/cfr_monitor.sv
// Checker of the feature bank write side.
// Assumes bind onto the cfr_feature_ctrl ports.
`timescale 1ns/1ps
`default_nettype none
module cfr_monitor (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       wr_stb,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic       retimed_data_output_en,
  input wire logic       recovered_clock_output_en,
  input wire logic       ddr_en,
  input wire logic       prbs_path_en,
  input wire logic       prbs_gen_en,
  input wire logic       prbs_det_en,
  input wire logic       prbs_start,
  input wire logic       holdover_en
);
  // ----------------
  // Properties
  // ----------------
  logic [7:0] d1_r;
  logic [7:0] d2_r;
  // Data delayed to line up with the two-edge update
  always @(posedge core_clk) begin
    d1_r <= wr_data;
    d2_r <= d1_r;
  end
  wire w22 = wr_stb && wr_addr == 8'h22;
  wire w1f = wr_stb && wr_addr == 8'h1F;
  wire w34 = wr_stb && wr_addr == 8'h34;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  AST_DATA_BUF:
    assert property (w22 |-> ##2 retimed_data_output_en != d2_r[6])
    else $error("data buffer enable wrong");
  AST_CLK_BUF:
    assert property (w22 |-> ##2 recovered_clock_output_en != d2_r[5])
    else $error("clock buffer enable wrong");
  AST_DDR:
    assert property (w1f |-> ##2 ddr_en == (d2_r[2:0] == 3'h2))
    else $error("ddr enable wrong");
  AST_PRBS_PATH:
    assert property (w1f |-> ##2 prbs_path_en == (d2_r[2:0] == 3'h5))
    else $error("sequence path enable wrong");
  AST_HOLD:
    assert property (w34 |-> ##2 holdover_en == (d2_r == 8'h02))
    else $error("holdover wrong");
  AST_START_PULSE:
    assert property (prbs_start |=> !prbs_start)
    else $error("start not a pulse");
  AST_GEN_DET_EXCL:
    assert property (!(prbs_gen_en && prbs_det_en))
    else $error("generate and detect together");
  AST_GEN_NEEDS_PATH:
    assert property (prbs_gen_en || prbs_det_en |-> prbs_path_en)
    else $error("sequence mode without path");
  cover property (prbs_start);
  cover property (holdover_en);
  cover property (ddr_en);
endmodule
bind cfr_feature_ctrl cfr_monitor cfr_monitor_i (.*);
`default_nettype wire

// File: verification/cfr_host.sv
// Host model: byte writes into the feature bank.
// Assumes the bench calls wr hierarchically.
`timescale 1ns/1ps
`default_nettype none
module cfr_host (
  input  wire logic       core_clk,
  output var  logic       wr_stb,
  output var  logic [7:0] wr_addr,
  output var  logic [7:0] wr_data
);
  // ----------------
  // Write cycle
  // ----------------
  initial begin
    wr_stb = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
  end
  // Data inverted after the strobe so stale bytes never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr_stb <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    wr_data <= ~d;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_cfr_feature_ctrl.sv
// Bench of the feature bank.
// Assumes cfr_host drives the write port.
`timescale 1ns/1ps
`default_nettype none
module tb_cfr_feature_ctrl;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic squelch_req = 1'b0;
  logic signal_loss_raw = 1'b0;
  wire wr_stb, signal_loss_indicator, retimed_data_output_en;
  wire recovered_clock_output_en, squelch_clk, squelch_data, ddr_en;
  wire prbs_path_en, prbs_gen_en, prbs_det_en, prbs_start, holdover_en;
  wire cdr_bypass, boost_output;
  wire [7:0] wr_addr, wr_data;
  int n_fail = 0;
  int checks = 0;
  int np = 0;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (prbs_start) np <= np + 1;
  cfr_host cfr_host_i (.*);
  cfr_feature_ctrl cfr_feature_ctrl_i (.*);
  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input string nm, input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Off-edge sampling avoids races with the design flops
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfr_host_i.wr(a, d);
    w(2);
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_buf;
    chk("data_en", retimed_data_output_en, 1);
    wr(8'h22, 8'h40);
    chk("data_en", retimed_data_output_en, 0);
    chk("clk_en", recovered_clock_output_en, 1);
    wr(8'h22, 8'h20);
    chk("clk_en", recovered_clock_output_en, 0);
    wr(8'h22, 8'h80);
    chk("bypass", cdr_bypass, 1);
    wr(8'h22, 8'h00);
    chk("bypass", cdr_bypass, 0);
    wr(8'h11, 8'h01);
    chk("boost", boost_output, 1);
    wr(8'h11, 8'h00);
    chk("boost", boost_output, 0);
    $display("t_buf done");
  endtask
  task automatic t_feat;
    for (int c = 2; c < 8; c += 3) begin
      wr(8'h1F, 8'(c));
      chk("ddr", ddr_en, c == 2);
      chk("path", prbs_path_en, c == 5);
    end
    $display("t_feat done");
  endtask
  task automatic t_prbs;
    wr(8'h22, 8'h09);
    np = 0;
    wr(8'h22, 8'h01);
    w(3);
    chk("start", np, 1);
    chk("gen", prbs_gen_en, 1);
    wr(8'h22, 8'h04);
    chk("det", prbs_det_en, 1);
    wr(8'h22, 8'h00);
    chk("det", prbs_det_en, 0);
    $display("t_prbs done");
  endtask
  task automatic t_pins;
    wr(8'h34, 8'h02);
    chk("hold", holdover_en, 1);
    signal_loss_raw <= 1'b1;
    squelch_req <= 1'b1;
    wr(8'h34, 8'h00);
    w(6);
    chk("hold", holdover_en, 0);
    chk("los", signal_loss_indicator, 1);
    chk("mute", {squelch_clk, squelch_data}, 3);
    wr(8'h11, 8'h06);
    squelch_req <= 1'b0;
    w(8);
    chk("los", signal_loss_indicator, 0);
    squelch_req <= 1'b1;
    w(8);
    chk("mute1", squelch_clk ^ squelch_data, 1);
    $display("t_pins done");
  endtask
  initial begin
    w(5);
    arst_n <= 1'b1;
    w(2);
    t_buf();
    t_feat();
    t_prbs();
    t_pins();
    give_verdict();
  end
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
